//--- verilog/gpp_port.sv
// Sixteen-pin general-purpose port with configuration registers and change events.
`timescale 1ns/100ps
`include "gpp_consts.svh"
module gpp_port #(
    parameter int PINS = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire gpp_pkg::gpp_req_s cfg_req,
    output gpp_pkg::gpp_rsp_s      cfg_rsp,
    input  wire logic [PINS-1:0]   general_input_pin,
    output logic      [PINS-1:0]   general_output_pin,
    output logic      [PINS-1:0]   general_pin_oe,
    input  wire logic [PINS-1:0]   alt_out,
    input  wire logic [PINS-1:0]   alt_oe,
    output logic                   cpu_event,
    output logic                   dma_event
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [PINS-1:0] pin_enable;
    logic [PINS-1:0] pin_direction;
    logic [PINS-1:0] pin_level_value;
    logic [PINS-1:0] rising_change_flags;
    logic [PINS-1:0] rising_change_mask;
    logic [PINS-1:0] falling_change_flags;
    logic [PINS-1:0] falling_change_mask;
    logic [2:0]      port_global_control;
    logic [PINS-1:0] event_polarity_select;
    logic [PINS-1:0] in_level;
    logic [PINS-1:0] in_rise;
    logic [PINS-1:0] in_fall;
    logic [PINS-1:0] is_output;
    logic [PINS-1:0] is_input;
    logic [PINS-1:0] value_read;
    logic [PINS-1:0] masked;
    logic [PINS-1:0] mask_all;
    logic            combined;
    logic            combined_last;
    logic            wr;
    logic            rd_ready;
    logic [31:0]     rd_data;
    logic [31:0]     next_rd_data;

    // Address compare for one register.
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
        hit = (addr[31:2] == off[31:2]);
    endfunction

    // Zero-extend a pin vector to a bus word.
    function automatic logic [31:0] word(input logic [PINS-1:0] v);
        word = {{(32 - PINS){1'b0}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin roles.

    // Direction only counts on enabled pins.
    assign is_output = pin_enable & pin_direction;
    assign is_input  = pin_enable & ~pin_direction;

    // Inputs are synchronised; drivers hold each level at least eight clocks.
    gpp_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .pin_async (general_input_pin),
        .polarity  (event_polarity_select),
        .level     (in_level),
        .rise      (in_rise),
        .fall      (in_fall)
    );

    // Pin drivers: enabled pins follow the port, others keep their other function.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            general_output_pin <= '0;
            general_pin_oe     <= '0;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                if (pin_enable[i]) begin
                    general_output_pin[i] <= pin_level_value[i];
                    general_pin_oe[i]     <= pin_direction[i];
                end else begin
                    general_output_pin[i] <= alt_out[i];
                    general_pin_oe[i]     <= alt_oe[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    assign wr = cfg_req.valid & cfg_req.write;

    // Enable register.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pin_enable <= `GPP_RST_ENABLE;
        end else if (wr && hit(cfg_req.addr, `GPP_OFF_ENABLE)) begin
            pin_enable <= cfg_req.wdata[PINS-1:0];
        end
    end

    // Direction register, all inputs after reset.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pin_direction <= `GPP_RST_DIRECTION;
        end else if (wr && hit(cfg_req.addr, `GPP_OFF_DIRECTION)) begin
            pin_direction <= cfg_req.wdata[PINS-1:0];
        end
    end

    // Value register holds the output levels.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pin_level_value <= `GPP_RST_VALUE;
        end else if (wr && hit(cfg_req.addr, `GPP_OFF_VALUE)) begin
            pin_level_value <= cfg_req.wdata[PINS-1:0];
        end
    end

    // Masks, polarity and global control.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rising_change_mask    <= `GPP_RST_MASK;
            falling_change_mask   <= `GPP_RST_MASK;
            event_polarity_select <= `GPP_RST_POLARITY;
            port_global_control   <= `GPP_RST_GLOBAL;
        end else if (wr) begin
            if (hit(cfg_req.addr, `GPP_OFF_RISE_MASK)) begin
                rising_change_mask <= cfg_req.wdata[PINS-1:0];
            end
            if (hit(cfg_req.addr, `GPP_OFF_FALL_MASK)) begin
                falling_change_mask <= cfg_req.wdata[PINS-1:0];
            end
            if (hit(cfg_req.addr, `GPP_OFF_POLARITY)) begin
                event_polarity_select <= cfg_req.wdata[PINS-1:0];
            end
            if (hit(cfg_req.addr, `GPP_OFF_GLOBAL)) begin
                port_global_control <= cfg_req.wdata[2:0];
            end
        end
    end

    // Rising change flags: edges of enabled inputs set, writing one clears, set wins.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rising_change_flags <= `GPP_RST_FLAGS;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                if (is_input[i] && in_rise[i]) begin
                    rising_change_flags[i] <= 1'b1;
                end else if (wr && hit(cfg_req.addr, `GPP_OFF_RISE_FLAG)
                             && cfg_req.wdata[i]) begin
                    rising_change_flags[i] <= 1'b0;
                end
            end
        end
    end

    // Falling change flags, same discipline.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            falling_change_flags <= `GPP_RST_FLAGS;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                if (is_input[i] && in_fall[i]) begin
                    falling_change_flags[i] <= 1'b1;
                end else if (wr && hit(cfg_req.addr, `GPP_OFF_FALL_FLAG)
                             && cfg_req.wdata[i]) begin
                    falling_change_flags[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event generation.

    // Masked flags combine either as any-of or as all-of.
    assign masked   = (rising_change_flags & rising_change_mask)
                    | (falling_change_flags & falling_change_mask);
    assign mask_all = rising_change_mask | falling_change_mask;

    always_comb begin
        if (port_global_control[`GPP_GC_AND_MODE] == gpp_pkg::GPP_COMB_ALL) begin
            combined = (|mask_all) && ((masked & mask_all) == mask_all);
        end else begin
            combined = |masked;
        end
    end

    // A new combined condition makes one pulse on each enabled event output.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            combined_last <= 1'b0;
            cpu_event     <= 1'b0;
            dma_event     <= 1'b0;
        end else begin
            combined_last <= combined;
            cpu_event     <= combined & ~combined_last
                           & port_global_control[`GPP_GC_CPU_EN];
            dma_event     <= combined & ~combined_last
                           & port_global_control[`GPP_GC_DMA_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Inputs read their sampled level; polling drivers hold twelve clocks.
    assign value_read = (is_output & pin_level_value)
                      | (~is_output & in_level);

    // Read multiplexer; unmapped and reserved words read zero.
    always_comb begin
        next_rd_data = 32'h00000000;
        if (hit(cfg_req.addr, `GPP_OFF_ENABLE)) begin
            next_rd_data = word(pin_enable);
        end else if (hit(cfg_req.addr, `GPP_OFF_DIRECTION)) begin
            next_rd_data = word(pin_direction);
        end else if (hit(cfg_req.addr, `GPP_OFF_VALUE)) begin
            next_rd_data = word(value_read);
        end else if (hit(cfg_req.addr, `GPP_OFF_RISE_FLAG)) begin
            next_rd_data = word(rising_change_flags);
        end else if (hit(cfg_req.addr, `GPP_OFF_RISE_MASK)) begin
            next_rd_data = word(rising_change_mask);
        end else if (hit(cfg_req.addr, `GPP_OFF_FALL_FLAG)) begin
            next_rd_data = word(falling_change_flags);
        end else if (hit(cfg_req.addr, `GPP_OFF_FALL_MASK)) begin
            next_rd_data = word(falling_change_mask);
        end else if (hit(cfg_req.addr, `GPP_OFF_GLOBAL)) begin
            next_rd_data = {29'h00000000, port_global_control};
        end else if (hit(cfg_req.addr, `GPP_OFF_POLARITY)) begin
            next_rd_data = word(event_polarity_select);
        end
    end

    // Every request is answered one cycle later with a one-cycle ready.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rd_ready <= 1'b0;
            rd_data  <= 32'h00000000;
        end else begin
            rd_ready <= cfg_req.valid;
            if (cfg_req.valid && !cfg_req.write) begin
                rd_data <= next_rd_data;
            end
        end
    end

    assign cfg_rsp.ready = rd_ready;
    assign cfg_rsp.rdata = rd_data;

endmodule

//--- verilog/gpp_consts.svh
// Constants of the general-purpose pin port: offsets, fields, reset values and timing.
// Behaviour
// - A pin is general-purpose only while its enable bit is one.
// - Direction bit zero makes the pin an input, one an output.
// - Direction has no effect on a pin whose enable bit is clear.
// - An output pin drives the bit written into the value register.
// - Reading the value register returns the sampled level of input pins.
// - Pin changes raise processor interrupts and DMA events by selectable mode.
// - Direction resets to zero; its upper half reads back zero.
// - Sixteen pins, 15 down to 0, each with enable and direction bit.
// - Map holds value, reserved word, change flags and masks, control, polarity.
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH

// Register byte addresses on the configuration bus.
`define GPP_OFF_ENABLE     32'h01b00000
`define GPP_OFF_DIRECTION  32'h01b00004
`define GPP_OFF_VALUE      32'h01b00008
`define GPP_OFF_RESERVED   32'h01b0000c
`define GPP_OFF_RISE_FLAG  32'h01b00010
`define GPP_OFF_RISE_MASK  32'h01b00014
`define GPP_OFF_FALL_FLAG  32'h01b00018
`define GPP_OFF_FALL_MASK  32'h01b0001c
`define GPP_OFF_GLOBAL     32'h01b00020
`define GPP_OFF_POLARITY   32'h01b00024

// Global control field positions.
`define GPP_GC_AND_MODE    0
`define GPP_GC_CPU_EN      1
`define GPP_GC_DMA_EN      2

// Reset values.
`define GPP_RST_ENABLE     16'h0000
`define GPP_RST_DIRECTION  16'h0000
`define GPP_RST_VALUE      16'h0000
`define GPP_RST_FLAGS      16'h0000
`define GPP_RST_MASK       16'h0000
`define GPP_RST_GLOBAL     3'h0
`define GPP_RST_POLARITY   16'h0000

// Timing, in clock periods, that the pin drivers must honour.
`define GPP_EVENT_HOLD_CYC 8
`define GPP_POLL_HOLD_CYC  12

`endif

//--- verilog/gpp_pkg.sv
// Types shared by the general-purpose pin port.
package gpp_pkg;

    // Configuration bus request.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } gpp_req_s;

    // Configuration bus answer.
    typedef struct packed {
        logic        ready;
        logic [31:0] rdata;
    } gpp_rsp_s;

    // Combination of masked change flags.
    typedef enum logic [0:0] {
        GPP_COMB_ANY = 1'b0,
        GPP_COMB_ALL = 1'b1
    } gpp_comb_e;

endpackage

//--- verilog/gpp_sync.sv
// Pin synchroniser with polarity and edge detection.
`timescale 1ns/100ps
module gpp_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] pin_async,
    input  wire logic [WIDTH-1:0] polarity,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] last_pol;
    logic [WIDTH-1:0] pol_level;

    // Two flip-flops bring the pins into the clock domain.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= pin_async;
            stage2 <= stage1;
        end
    end

    // Polarity turns the active edge into the rising one.
    assign pol_level = stage2 ^ polarity;

    // The previous polarised level serves the edge detector.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            last_pol <= '0;
        end else begin
            last_pol <= pol_level;
        end
    end

    assign level = stage2;
    assign rise  = pol_level & ~last_pol;
    assign fall  = ~pol_level & last_pol;

endmodule

//--- testbench/gpp_port_props.sv
// Checker for the pin port: bus answers, pin drive and change events.
`timescale 1ns/100ps
`include "gpp_consts.svh"
module gpp_port_props #(
    parameter int PINS = 16
) (
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire gpp_pkg::gpp_req_s cfg_req,
    input wire gpp_pkg::gpp_rsp_s cfg_rsp,
    input wire logic [PINS-1:0]   general_input_pin,
    input wire logic [PINS-1:0]   general_output_pin,
    input wire logic [PINS-1:0]   general_pin_oe,
    input wire logic [PINS-1:0]   alt_out,
    input wire logic [PINS-1:0]   alt_oe,
    input wire logic              cpu_event,
    input wire logic              dma_event
);
    logic [PINS-1:0] en;
    logic [PINS-1:0] dir;
    logic [PINS-1:0] val;
    logic [2:0]      gc;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    // Shadow copies of the control registers, taken from every write.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            en  <= '0;
            dir <= '0;
            val <= '0;
            gc  <= '0;
        end else if (cfg_req.valid && cfg_req.write) begin
            case (cfg_req.addr & 32'hfffffffc)
                `GPP_OFF_ENABLE:    en  <= cfg_req.wdata[PINS-1:0];
                `GPP_OFF_DIRECTION: dir <= cfg_req.wdata[PINS-1:0];
                `GPP_OFF_VALUE:     val <= cfg_req.wdata[PINS-1:0];
                `GPP_OFF_GLOBAL:    gc  <= cfg_req.wdata[2:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////
    // Bus answers, pin drive and event gating.
    a_bus_answer: assert property (cfg_req.valid |=> cfg_rsp.ready)
        else $error("Request got no answer one cycle later.");
    a_no_stray_answer: assert property (cfg_rsp.ready |-> $past(cfg_req.valid))
        else $error("Answer without a request.");
    a_upper_zero: assert property (cfg_req.valid && !cfg_req.write |=>
        cfg_rsp.rdata[31:16] == 16'h0)
        else $error("Upper half of a read is not zero.");
    a_alt_when_off: assert property ($past(rstn) |->
        (((general_pin_oe ^ $past(alt_oe)) | (general_output_pin ^ $past(alt_out)))
         & ~$past(en)) == '0)
        else $error("Disabled pin does not follow its other function.");
    a_dir_sets_oe: assert property ($past(rstn) |->
        ((general_pin_oe ^ $past(dir)) & $past(en)) == '0)
        else $error("Enabled pin drive does not match its direction.");
    a_out_follows_val: assert property ($past(rstn) |->
        ((general_output_pin ^ $past(val)) & $past(en) & $past(dir)) == '0)
        else $error("Output pin does not follow the value register.");
    a_cpu_gated: assert property (cpu_event |-> $past(gc[1]) ##1 !cpu_event)
        else $error("Interrupt pulse not gated or too long.");
    a_dma_gated: assert property (dma_event |-> $past(gc[2]) ##1 !dma_event)
        else $error("DMA pulse not gated or too long.");
    a_reset_quiet: assert property (disable iff (1'b0) !rstn |=>
        general_pin_oe == '0 && !cpu_event && !dma_event && !cfg_rsp.ready)
        else $error("Outputs not quiet after reset.");
    c_cpu: cover property (cpu_event);
    c_dma: cover property (dma_event);
    c_write: cover property (cfg_req.valid && cfg_req.write);
endmodule

bind gpp_port gpp_port_props #(.PINS(PINS)) i_gpp_port_props (
    .clk_sys(clk_sys), .rstn(rstn), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .general_input_pin(general_input_pin), .general_output_pin(general_output_pin),
    .general_pin_oe(general_pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
    .cpu_event(cpu_event), .dma_event(dma_event));

//--- testbench/gpp_pin_model.sv
// Model of the devices on the pins: drives inputs and sees driven outputs.
`timescale 1ns/100ps
module gpp_pin_model #(
    parameter int PINS = 16,
    parameter int HOLD = 12
) (
    input  wire logic            clk_sys,
    input  wire logic [PINS-1:0] level_req,
    input  wire logic [PINS-1:0] drive_out,
    input  wire logic [PINS-1:0] drive_oe,
    output logic      [PINS-1:0] pin_wire
);
    logic [PINS-1:0] level = '0;
    int              held  = 0;
    // A new level is taken only once the old one has stood HOLD clocks.
    always @(posedge clk_sys) begin
        if (level_req != level && held >= HOLD) begin
            level <= level_req;
            held  <= 0;
        end else if (held < HOLD) begin
            held <= held + 1;
        end
    end
    // Each pin shows the port's level while it drives, the device's otherwise.
    assign pin_wire = (drive_oe & drive_out) | (~drive_oe & level);
endmodule

//--- testbench/test_gpp_port.sv
// Self-checking testbench of the general-purpose pin port.
`timescale 1ns/100ps
`include "gpp_consts.svh"
module test_gpp_port;
    logic              clk_sys   = 1'b0;
    logic              rstn      = 1'b0;
    gpp_pkg::gpp_req_s cfg_req   = '0;
    gpp_pkg::gpp_rsp_s cfg_rsp;
    logic [15:0]       pins;
    logic [15:0]       out_pin;
    logic [15:0]       oe_pin;
    logic [15:0]       alt_out   = 16'h0;
    logic [15:0]       alt_oe    = 16'h0;
    logic [15:0]       level_req = 16'h0;
    logic              cpu_ev;
    logic              dma_ev;
    logic [31:0]       rd;
    int                fails       = 0;
    int                checks_done = 0;
    int                cycles      = 0;

    gpp_port i_gpp_port (.clk_sys(clk_sys), .rstn(rstn), .cfg_req(cfg_req),
        .cfg_rsp(cfg_rsp), .general_input_pin(pins), .general_output_pin(out_pin),
        .general_pin_oe(oe_pin), .alt_out(alt_out), .alt_oe(alt_oe),
        .cpu_event(cpu_ev), .dma_event(dma_ev));
    gpp_pin_model i_gpp_pin_model (.clk_sys(clk_sys), .level_req(level_req),
        .drive_out(out_pin), .drive_oe(oe_pin), .pin_wire(pins));

    ////////////////////////////////////////
    // Clock and hang guard.
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One bus request; the answer is due exactly one cycle after it is taken.
    task automatic cfg_xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cfg_req <= '{1'b1, w, a, d};
        @(posedge clk_sys);
        cfg_req.valid <= 1'b0;
        @(posedge clk_sys);
        check({31'h0, cfg_rsp.ready}, 32'h1);
        rd = cfg_rsp.rdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        cfg_xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        cfg_xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Moves the far-side levels, then counts event pulses for 16 clocks.
    task automatic ev_step(input logic [15:0] lv, input int ec, input int ed);
        int nc;
        int nd;
        nc = 0;
        nd = 0;
        @(posedge clk_sys);
        level_req <= lv;
        repeat (16) begin
            @(posedge clk_sys);
            nc += (cpu_ev === 1'b1);
            nd += (dma_ev === 1'b1);
        end
        check(nc, ec);
        check(nd, ed);
    endtask

    ////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int a = 0; a <= 'h28; a += 4) rd_chk(`GPP_OFF_ENABLE + a, 32'h0);
        wr(`GPP_OFF_DIRECTION, 32'hffffffff);
        rd_chk(`GPP_OFF_DIRECTION, 32'h0000ffff);
        wr(`GPP_OFF_RESERVED, 32'hffffffff);
        rd_chk(`GPP_OFF_RESERVED, 32'h0);
        wr(`GPP_OFF_RISE_MASK, 32'h12345678);
        rd_chk(`GPP_OFF_RISE_MASK, 32'h00005678);
        wr(`GPP_OFF_RISE_MASK, 32'h0);
        alt_out <= 16'ha5a5;
        alt_oe  <= 16'h0ff0;
        repeat (2) @(posedge clk_sys);
        check(oe_pin, 16'h0ff0);
        check(out_pin, 16'ha5a5);
        wr(`GPP_OFF_ENABLE, 32'h00ff);
        wr(`GPP_OFF_DIRECTION, 32'h000f);
        wr(`GPP_OFF_VALUE, 32'hfff5);
        @(posedge clk_sys);
        check(oe_pin, 16'h0f0f);
        check(out_pin & 16'hff0f, 16'ha505);
        alt_oe <= 16'h0;
        ev_step(16'h3c30, 0, 0);
        rd_chk(`GPP_OFF_VALUE, 32'h00003c35);
        rd_chk(`GPP_OFF_RISE_FLAG, 32'h00000030);
        ev_step(16'h0000, 0, 0);
        wr(`GPP_OFF_FALL_FLAG, 32'hffff);
        wr(`GPP_OFF_RISE_FLAG, 32'hffff);
        rd_chk(`GPP_OFF_RISE_FLAG, 32'h0);
        wr(`GPP_OFF_RISE_MASK, 32'h0010);
        wr(`GPP_OFF_GLOBAL, 32'h2);
        ev_step(16'h0010, 1, 0);
        wr(`GPP_OFF_RISE_FLAG, 32'hffff);
        wr(`GPP_OFF_RISE_MASK, 32'h0);
        wr(`GPP_OFF_FALL_MASK, 32'h0010);
        wr(`GPP_OFF_GLOBAL, 32'h4);
        ev_step(16'h0000, 0, 1);
        wr(`GPP_OFF_FALL_FLAG, 32'hffff);
        wr(`GPP_OFF_FALL_MASK, 32'h0);
        wr(`GPP_OFF_RISE_MASK, 32'h0030);
        wr(`GPP_OFF_GLOBAL, 32'h3);
        ev_step(16'h0010, 0, 0);
        ev_step(16'h0030, 1, 0);
        // Inverted polarity on pin 4 turns its falling pin edge into a rising flag.
        wr(`GPP_OFF_POLARITY, 32'h0010);
        rd_chk(`GPP_OFF_POLARITY, 32'h00000010);
        wr(`GPP_OFF_FALL_FLAG, 32'hffff);
        wr(`GPP_OFF_RISE_FLAG, 32'hffff);
        ev_step(16'h0000, 0, 0);
        rd_chk(`GPP_OFF_RISE_FLAG, 32'h00000010);
        rd_chk(`GPP_OFF_FALL_FLAG, 32'h00000020);
        give_verdict();
    end
endmodule
